// [dv/host_link_model.sv]
module host_link_model (
  // Serial link
  output logic link_sclk,
  output logic cs_n,
  output logic sio0_in,
  input wire logic sio1_out,
  input wire logic sio1_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b1;
    sio0_in = 1'b0;
  end

  // Clock only inside frames; opcode MSB first, then zero padding
  task automatic frame(input logic [7:0] op, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      sio0_in = (i < 8) ? op[7-i] : 1'b0;
      if (i >= 8) rd = {rd[6:0], sio1_oe ? sio1_out : 1'bx};
      #62.5 link_sclk = 1'b1;
      #62.5 link_sclk = 1'b0;
    end
    cs_n = 1'b1;
    // Released line must not look held
    sio0_in = ~sio0_in;
    #25;
  endtask : frame
endmodule : host_link_model

// [dv/otp_suspend_ctrl_props.sv]
module otp_suspend_ctrl_props
  import otp_suspend_pkg::*;
#(
  parameter logic [7:0] OP_STATUS_WRITE = 8'h01
) (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire logic cs_n,
  input wire logic sio1_oe,
  input wire logic [7:0] cmd_query_op,
  input wire logic cmd_query_ok,
  input wire logic otp_select,
  input wire logic factory_lock_nv,
  input wire logic lockdown_nv_write,
  input wire logic write_latch_clear,
  input wire logic write_latch_set,
  input wire logic write_busy_set,
  input wire logic suspend_hold,
  input wire logic [7:0] security_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // NV bits are only valid a few edges after reset
  logic [1:0] up_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end

  chk_oe_select: assert property (sio1_oe |-> !cs_n)
    else $error("output enabled without select");
  chk_reserved_zero: assert property (!security_reg[7] && !security_reg[4])
    else $error("reserved bit set");
  chk_factory_bit: assert property (up_reg == 2'h3 |-> security_reg[0] == factory_lock_nv)
    else $error("factory bit differs from storage");
  chk_lock_sticky: assert property (up_reg == 2'h3 && $past(security_reg[1]) |-> security_reg[1])
    else $error("lock bit cleared");
  chk_lock_commit: assert property (lockdown_nv_write |-> !$past(security_reg[1]) ##1 security_reg[1])
    else $error("lock commit wrong");
  chk_wait_latency: assert property ($rose(suspend_hold) |-> !(security_reg[2] || security_reg[3]) [*8])
    else $error("suspend flag before latency");
  chk_flag_with_clear: assert property ($rose(security_reg[2]) || $rose(security_reg[3])
    |-> write_latch_clear && suspend_hold)
    else $error("flag set without latch clear");
  chk_resume_pulses: assert property ($fell(security_reg[2]) || $fell(security_reg[3])
    |-> write_latch_set && write_busy_set && !suspend_hold)
    else $error("resume pulses missing");
  chk_otp_no_status: assert property (otp_select && cmd_query_op == OP_STATUS_WRITE |-> !cmd_query_ok)
    else $error("status write allowed in otp mode");
  chk_psus_no_write_latch_set_cmd: assert property (security_reg[2] && cmd_query_op == OP_WRITE_LATCH_SET |-> !cmd_query_ok)
    else $error("write latch set in program suspend");
  chk_sec_read_any: assert property (suspend_hold && cmd_query_op == OP_SEC_READ |-> cmd_query_ok)
    else $error("security read refused");

  cover property ($rose(security_reg[2]));
  cover property ($rose(security_reg[3]));
  cover property (lockdown_nv_write);
endmodule : otp_suspend_ctrl_props

bind otp_suspend_ctrl otp_suspend_ctrl_props #(.OP_STATUS_WRITE(OP_STATUS_WRITE)) i_otp_suspend_ctrl_props (
  .clk_sys, .rst_n, .cs_n, .sio1_oe, .cmd_query_op, .cmd_query_ok, .otp_select, .factory_lock_nv,
  .lockdown_nv_write, .write_latch_clear, .write_latch_set, .write_busy_set, .suspend_hold, .security_reg);

// [dv/tb.sv]
module tb
  import otp_suspend_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] SUSP_OP = 8'hB0;
  localparam logic [7:0] SEC_WR_OP = 8'h2F;
  localparam logic [7:0] STAT_WR_OP = 8'h01;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic link_sclk, cs_n, sio0_in, sio1_out, sio1_oe, cmd_query_ok, addr_query_ok, otp_select;
  logic lockdown_nv_write, write_latch_clear, write_latch_set, write_busy_set, suspend_hold;
  logic [7:0] security_reg, rd;
  logic [7:0] cmd_query_op = OP_NOP;
  logic [ADDR_W-1:0] addr_query = '0, op_addr = '0;
  logic addr_query_write = 1'b0, write_latch_bit = 1'b0, program_active = 1'b0, erase_active = 1'b0;
  logic prog_done = 1'b0, prog_fail = 1'b0, erase_done = 1'b0, erase_fail = 1'b0;
  // Factory-locked part, customer lock still open
  logic factory_lock_nv = 1'b1, lockdown_nv = 1'b0;
  erase_size_t op_erase_size = SIZE_SECTOR_4K;
  int n_errors = 0, n_compared = 0, cycles = 0, n_wl_clr = 0, n_lock_wr = 0;

  otp_suspend_ctrl #(.OP_SUSPEND(SUSP_OP), .OP_SEC_WRITE(SEC_WR_OP), .OP_STATUS_WRITE(STAT_WR_OP),
    .PROG_SUS_LAT_NS(200), .ERASE_SUS_LAT_NS(200)) i_otp_suspend_ctrl (.clk_sys, .rst_n, .link_sclk,
    .cs_n, .sio0_in, .sio1_out, .sio1_oe, .cmd_query_op, .cmd_query_ok, .addr_query, .addr_query_write,
    .addr_query_ok, .otp_select, .write_latch_bit, .program_active, .erase_active, .op_addr,
    .op_erase_size, .prog_done, .prog_fail, .erase_done, .erase_fail, .factory_lock_nv, .lockdown_nv,
    .lockdown_nv_write, .write_latch_clear, .write_latch_set, .write_busy_set, .suspend_hold,
    .security_reg);
  host_link_model i_host_link_model (.link_sclk, .cs_n, .sio0_in, .sio1_out, .sio1_oe);

  always #2.5 clk_sys = ~clk_sys;

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Wait covers command effect and the gap between frames
  task automatic send(input logic [7:0] op, input int nb = 8);
    i_host_link_model.frame(op, nb, rd);
    cyc(6);
  endtask : send
  task automatic q(input logic [7:0] op, input logic exp);
    @(posedge clk_sys) cmd_query_op <= op;
    #1 cmp({7'h00, cmd_query_ok}, {7'h00, exp});
  endtask : q
  task automatic aq(input logic [ADDR_W-1:0] a, input logic wr, input logic exp);
    @(posedge clk_sys) begin
      addr_query <= a;
      addr_query_write <= wr;
    end
    #1 cmp({7'h00, addr_query_ok}, {7'h00, exp});
  endtask : aq

  task automatic t_read;
    @(posedge clk_sys) program_active <= 1'b1;
    send(OP_SEC_READ, 24);
    cmp(rd, 8'h01);
    @(posedge clk_sys) program_active <= 1'b0;
    $display("test read done");
  endtask : t_read
  task automatic t_otp;
    @(posedge clk_sys) write_latch_bit <= 1'b1;
    send(OP_OTP_ENTER);
    cmp({7'h00, otp_select}, 8'h01);
    q(STAT_WR_OP, 1'b0);
    aq(24'h000000, 1'b1, 1'b1);
    aq(24'h000200, 1'b1, 1'b0);
    send(SEC_WR_OP);
    cmp(security_reg, 8'h01);
    send(OP_OTP_EXIT);
    cmp({7'h00, otp_select}, 8'h00);
    $display("test otp done");
  endtask : t_otp
  task automatic t_lock;
    send(SEC_WR_OP, 12);
    cmp(security_reg, 8'h01);
    @(posedge clk_sys) write_latch_bit <= 1'b0;
    send(SEC_WR_OP);
    cmp(security_reg, 8'h01);
    @(posedge clk_sys) write_latch_bit <= 1'b1;
    send(SEC_WR_OP);
    cmp(security_reg, 8'h03);
    cmp(8'(n_lock_wr), 8'h01);
    cmp(8'(n_wl_clr), 8'h01);
    @(posedge clk_sys) write_latch_bit <= 1'b0;
    send(OP_OTP_ENTER);
    q(OP_PAGE_PROG, 1'b0);
    q(OP_READ, 1'b1);
    aq(24'h000000, 1'b1, 1'b0);
    send(OP_OTP_EXIT);
    cmp({7'h00, otp_select}, 8'h00);
    $display("test lock done");
  endtask : t_lock
  task automatic t_sus(input int k);
    @(posedge clk_sys) begin
      program_active <= (k == 0);
      erase_active <= (k == 1);
      op_addr <= 24'h012345;
    end
    send(SUSP_OP);
    cmp({7'h00, suspend_hold}, 8'h01);
    cmp(security_reg, 8'h03);
    q(OP_SEC_READ, 1'b1);
    q(OP_READ, 1'b0);
    cyc(40);
    cmp(security_reg, (k == 0) ? 8'h07 : 8'h0B);
    cmp(8'(n_wl_clr), 8'(2 + k));
    q(OP_WRITE_LATCH_SET, k == 1);
    q(OP_QUAD_IO_READ, 1'b1);
    q(STAT_WR_OP, 1'b0);
    q(OP_PAGE_PROG, k == 1);
    aq(24'h0123F0, 1'b0, 1'b0);
    aq(24'h013000, 1'b0, 1'b1);
    aq(24'h013000, 1'b1, k == 1);
    send(STAT_WR_OP);
    cmp(security_reg, (k == 0) ? 8'h07 : 8'h0B);
    if (k == 1) begin
      @(posedge clk_sys) program_active <= 1'b1;
      send(OP_RESUME_A);
      cmp(security_reg, 8'h0B);
      @(posedge clk_sys) program_active <= 1'b0;
    end
    send((k == 0) ? OP_RESUME_A : OP_RESUME_B);
    cmp(security_reg, 8'h03);
    cmp({7'h00, suspend_hold}, 8'h00);
    @(posedge clk_sys) {program_active, erase_active} <= 2'b00;
    $display("test suspend %0d done", k);
  endtask : t_sus
  task automatic t_fail;
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_sys) begin
        prog_done <= (j < 2);
        erase_done <= (j >= 2);
        prog_fail <= (j % 2 == 0);
        erase_fail <= (j % 2 == 0);
      end
      @(posedge clk_sys) {prog_done, erase_done} <= 2'b00;
      cyc(2);
      cmp(security_reg, (j % 2 == 1) ? 8'h03 : ((j < 2) ? 8'h23 : 8'h43));
    end
    $display("test fail flags done");
  endtask : t_fail

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(4);
    cmp(security_reg, 8'h01);
    t_read();
    t_otp();
    t_lock();
    t_sus(0);
    t_sus(1);
    t_fail();
    complete_run();
  end

  // Whole run needs well under 8000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (write_latch_clear) n_wl_clr++;
    if (lockdown_nv_write) n_lock_wr++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
endmodule : tb

// [src/otp_suspend_ctrl.sv]
// How it works
// [RQ1] Enter command steers read and program paths to the separate 8K-bit OTP area.
// [RQ2] Opcode B1h alone in a frame enters OTP mode; upper lines ignored. The code also accepts B1h followed by further whole bytes.
// [RQ3] Opcode C1h alone in a frame leaves OTP mode, main array back. The code also accepts C1h followed by further whole bytes.
// [RQ4] In OTP mode refuse status/security writes; locked OTP allows reads only.
// [RQ5] In OTP mode no main array access is allowed.
// [RQ6] Security register read is served at all times, even while busy.
// [RQ7] Security byte repeats on serial output until select rises.
// [RQ8] Bit 0 shows read-only factory lock of the second OTP half.
// [RQ9] Bit 1 lock, settable once, then bit and first OTP half frozen.
// [RQ10] Bit 2 set when program suspended, cleared on resume.
// [RQ11] Bit 3 set when erase suspended, cleared on resume.
// [RQ12] Bit 5 set by failed or protected program, cleared by good program.
// [RQ13] Bit 6 set by failed or protected erase, cleared by good erase.
// [RQ14] Security write needs the write latch and changes only bit 1.
// [RQ15] Security write rejected unless select rises on a byte boundary.
// [RQ16] Suspend pauses page program, sector erase or block erase.
// [RQ17] While suspended, reads everywhere except the page or erase region.
// [RQ18] After suspend latency, clear write latch, set flag, open permitted commands.
// [RQ19] After latency allow listed reads and ids; write-latch set only in erase suspend.
// [RQ20] Status, security read and reset commands allowed right after suspend.
// [RQ21] Resume sets write latch and busy, clears suspend flag, continues.
// [RQ22] Erase suspend permits programming outside the suspended erase region.
// [RQ23] Program started in erase suspend cannot be suspended.
// [RQ24] Commands outside permitted lists ignored while suspended.
// [RQ25] Bits 4 and 7 read zero, writes ignored.
module otp_suspend_ctrl
  import otp_suspend_pkg::*;
#(
  parameter logic [7:0] OP_SUSPEND = 8'hB0,
  parameter logic [7:0] OP_SEC_WRITE = 8'h2F,
  parameter logic [7:0] OP_STATUS_WRITE = 8'h01,
  parameter int PROG_SUS_LAT_NS = 20000,
  parameter int ERASE_SUS_LAT_NS = 20000
) (
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial link
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic sio0_in,
  output logic sio1_out,
  output logic sio1_oe,
  // Command and address gating for the decoder
  input wire logic [7:0] cmd_query_op,
  output logic cmd_query_ok,
  input wire logic [ADDR_W-1:0] addr_query,
  input wire logic addr_query_write,
  output logic addr_query_ok,
  output logic otp_select,
  // Core operation status
  input wire logic write_latch_bit,
  input wire logic program_active,
  input wire logic erase_active,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire erase_size_t op_erase_size,
  input wire logic prog_done,
  input wire logic prog_fail,
  input wire logic erase_done,
  input wire logic erase_fail,
  // Non-volatile bits
  input wire logic factory_lock_nv,
  input wire logic lockdown_nv,
  output logic lockdown_nv_write,
  // Core control
  output logic write_latch_clear,
  output logic write_latch_set,
  output logic write_busy_set,
  output logic suspend_hold,
  output logic [7:0] security_reg
);

  localparam logic [SUS_CNT_W-1:0] PROG_SUS_CYC =
    SUS_CNT_W'((PROG_SUS_LAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [SUS_CNT_W-1:0] ERASE_SUS_CYC =
    SUS_CNT_W'((ERASE_SUS_LAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] bitpos;
    logic have_op;
    logic out_bit;
    logic out_en;
    logic [7:0] sec_s1;
    logic [7:0] sec_s2;
  } link_st_t;

  link_st_t lnk_reg, lnk_next;
  logic frame_fresh_reg;
  logic [7:0] new_op;
  logic [2:0] new_pos;

  // Frame start marker; select high presets it, first clock edge clears it
  always_ff @(posedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      frame_fresh_reg <= 1'b1;
    end else begin
      frame_fresh_reg <= 1'b0;
    end
  end

  always_comb begin
    lnk_next = lnk_reg;
    new_op = {lnk_reg.opcode[6:0], sio0_in};
    new_pos = lnk_reg.bitpos + 3'd1;
    lnk_next.sec_s1 = security_reg;
    lnk_next.sec_s2 = lnk_reg.sec_s1;
    if (frame_fresh_reg) begin
      lnk_next.opcode = {7'h00, sio0_in};
      lnk_next.bitpos = 3'd1;
      lnk_next.have_op = 1'b0;
      lnk_next.out_en = 1'b0;
    end else begin
      lnk_next.bitpos = new_pos;
      if (!lnk_reg.have_op) begin
        lnk_next.opcode = new_op;
        if (new_pos == 3'd0) begin
          lnk_next.have_op = 1'b1;
          if (new_op == OP_SEC_READ) begin
            lnk_next.out_en = 1'b1; // see [RQ6]
            lnk_next.out_bit = lnk_reg.sec_s2[7];
          end
        end
      end else if (lnk_reg.out_en) begin
        lnk_next.out_bit = lnk_reg.sec_s2[3'd7 - new_pos]; // see [RQ7]
      end
    end
  end

  always_ff @(posedge link_sclk or negedge rst_n) begin
    if (!rst_n) begin
      lnk_reg <= '0;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  // Output drops the moment select rises, stale frames never drive
  assign sio1_out = lnk_reg.out_bit;
  assign sio1_oe = lnk_reg.out_en & ~cs_n & ~frame_fresh_reg;

  // ----------------------------------------
  // System domain
  // ----------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic loaded;
    logic factory;
    logic lock;
    logic otp_mode;
    logic psus;
    logic esus;
    logic pfail;
    logic efail;
    sus_state_t sus;
    logic sus_erase;
    logic [SUS_CNT_W-1:0] sus_cnt;
    logic [ADDR_W-1:0] sus_addr;
    logic [4:0] sus_lsb;
    logic lock_wr;
    logic wl_clr;
    logic wl_set;
    logic busy_set;
    logic [7:0] sec;
  } sys_st_t;

  sys_st_t sys_reg, sys_next;
  logic frame_end;
  logic frame_ok;
  logic [7:0] frame_op;
  logic frame_allowed;

  function automatic logic is_read_op(input logic [7:0] op);
    is_read_op = (op == OP_READ) || (op == OP_FAST_READ) || (op == OP_DUAL_OUT_READ) ||
                 (op == OP_QUAD_OUT_READ) || (op == OP_DUAL_IO_READ) || (op == OP_QUAD_IO_READ);
  endfunction : is_read_op

  function automatic logic is_anytime_op(input logic [7:0] op);
    is_anytime_op = (op == OP_STATUS_READ) || (op == OP_SEC_READ) || (op == OP_RESET_ARM) ||
                    (op == OP_RESET_GO) || (op == OP_WRITE_LATCH_CLR) || (op == OP_CONFIG_READ) ||
                    (op == OP_SIGNATURE_READ) || (op == OP_NOP);
  endfunction : is_anytime_op

  function automatic logic cmd_allowed(input logic [7:0] op, input sys_st_t s);
    logic ok;
    logic held_list;
    ok = 1'b1;
    held_list = is_read_op(op) || (op == OP_SFDP_READ) || (op == OP_ID_READ) ||
                (op == OP_MAKER_ID_READ) || (op == OP_OTP_ENTER) || (op == OP_OTP_EXIT) ||
                (op == OP_BURST_LEN_SET) || (op == OP_RESUME_A) || (op == OP_RESUME_B);
    if (s.otp_mode && ((op == OP_STATUS_WRITE) || (op == OP_SEC_WRITE))) begin
      ok = 1'b0; // see [RQ4]
    end
    if (s.otp_mode && s.lock && !is_read_op(op) && !is_anytime_op(op) && (op != OP_OTP_EXIT)) begin
      ok = 1'b0; // see [RQ4]
    end
    if (s.sus == SUS_WAIT && !is_anytime_op(op)) begin
      ok = 1'b0; // see [RQ20]
    end
    if (s.sus == SUS_HELD && !is_anytime_op(op)) begin
      if (s.sus_erase) begin
        ok = ok && (held_list || (op == OP_WRITE_LATCH_SET) || (op == OP_PAGE_PROG) ||
                    (op == OP_QUAD_PAGE_PROG)); // see [RQ19] [RQ22] [RQ24]
      end else begin
        ok = ok && held_list; // see [RQ19] [RQ24]
      end
    end
    cmd_allowed = ok;
  endfunction : cmd_allowed

  // Link words are quiet once select is high and the link clock has stopped
  assign frame_end = sys_reg.cs_s2 & ~sys_reg.cs_s3;
  assign frame_op = lnk_reg.opcode;
  assign frame_ok = lnk_reg.have_op & (lnk_reg.bitpos == 3'd0); // see [RQ15]
  assign frame_allowed = cmd_allowed(frame_op, sys_reg);

  always_comb begin
    sys_next = sys_reg;
    sys_next.cs_s1 = cs_n;
    sys_next.cs_s2 = sys_reg.cs_s1;
    sys_next.cs_s3 = sys_reg.cs_s2;
    sys_next.lock_wr = 1'b0;
    sys_next.wl_clr = 1'b0;
    sys_next.wl_set = 1'b0;
    sys_next.busy_set = 1'b0;
    // Non-volatile bits are caught once after reset release
    if (!sys_reg.loaded) begin
      sys_next.loaded = 1'b1;
      sys_next.factory = factory_lock_nv; // see [RQ8]
      sys_next.lock = lockdown_nv;
    end
    if (prog_done) begin
      sys_next.pfail = prog_fail; // see [RQ12]
    end
    if (erase_done) begin
      sys_next.efail = erase_fail; // see [RQ13]
    end
    unique case (sys_reg.sus)
      SUS_IDLE: begin
        if (frame_end && frame_ok && frame_op == OP_SUSPEND && (program_active || erase_active)) begin
          sys_next.sus = SUS_WAIT; // see [RQ16]
          sys_next.sus_erase = !program_active;
          sys_next.sus_addr = op_addr;
          sys_next.sus_cnt = program_active ? PROG_SUS_CYC : ERASE_SUS_CYC;
          if (program_active) begin
            sys_next.sus_lsb = 5'(PAGE_LSB);
          end else if (op_erase_size == SIZE_BLOCK_64K) begin
            sys_next.sus_lsb = 5'(BLOCK_64K_LSB);
          end else if (op_erase_size == SIZE_BLOCK_32K) begin
            sys_next.sus_lsb = 5'(BLOCK_32K_LSB);
          end else begin
            sys_next.sus_lsb = 5'(SECTOR_4K_LSB);
          end
        end
      end
      SUS_WAIT: begin
        if (sys_reg.sus_cnt <= SUS_CNT_W'(1)) begin
          sys_next.sus = SUS_HELD; // see [RQ18]
          sys_next.wl_clr = 1'b1;
          sys_next.psus = !sys_reg.sus_erase; // see [RQ10]
          sys_next.esus = sys_reg.sus_erase; // see [RQ11]
        end else begin
          sys_next.sus_cnt = sys_reg.sus_cnt - SUS_CNT_W'(1);
        end
      end
      SUS_HELD: begin
        // A program running inside erase suspend blocks resume; suspend is not decoded here
        if (frame_end && frame_ok && frame_allowed && !(sys_reg.sus_erase && program_active) &&
            (frame_op == OP_RESUME_A || frame_op == OP_RESUME_B)) begin
          sys_next.sus = SUS_IDLE; // see [RQ21] [RQ23]
          sys_next.wl_set = 1'b1;
          sys_next.busy_set = 1'b1;
          sys_next.psus = SEC_VOLATILE_RESET; // see [RQ10]
          sys_next.esus = SEC_VOLATILE_RESET; // see [RQ11]
        end
      end
      default: begin
        sys_next.sus = SUS_IDLE;
      end
    endcase
    if (frame_end && frame_ok && frame_allowed) begin
      if (frame_op == OP_OTP_ENTER) begin
        sys_next.otp_mode = 1'b1; // see [RQ1] [RQ2]
      end
      if (frame_op == OP_OTP_EXIT) begin
        sys_next.otp_mode = 1'b0; // see [RQ3]
      end
      if (frame_op == OP_SEC_WRITE && write_latch_bit) begin
        sys_next.lock = 1'b1; // see [RQ9] [RQ14]
        sys_next.lock_wr = !sys_reg.lock;
        sys_next.wl_clr = 1'b1;
      end
    end
    sys_next.sec = 8'h00; // see [RQ25]
    sys_next.sec[SEC_FACTORY_BIT] = sys_next.factory;
    sys_next.sec[SEC_LOCK_BIT] = sys_next.lock;
    sys_next.sec[SEC_PSUS_BIT] = sys_next.psus;
    sys_next.sec[SEC_ESUS_BIT] = sys_next.esus;
    sys_next.sec[SEC_PFAIL_BIT] = sys_next.pfail;
    sys_next.sec[SEC_EFAIL_BIT] = sys_next.efail;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_reg <= '0;
      sys_reg.cs_s1 <= 1'b1;
      sys_reg.cs_s2 <= 1'b1;
      sys_reg.cs_s3 <= 1'b1;
      sys_reg.sus <= SUS_IDLE;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ----------------------------------------
  // Gating toward the core
  // ----------------------------------------
  always_comb begin
    cmd_query_ok = cmd_allowed(cmd_query_op, sys_reg);
    addr_query_ok = 1'b1;
    if (sys_reg.otp_mode) begin
      // Address selects the OTP area only, never the main array
      if (addr_query_write) begin
        addr_query_ok = addr_query[OTP_HALF_BIT] ? !sys_reg.factory : !sys_reg.lock; // see [RQ5] [RQ9]
      end
    end else if (sys_reg.sus == SUS_HELD) begin
      if ((addr_query >> sys_reg.sus_lsb) == (sys_reg.sus_addr >> sys_reg.sus_lsb)) begin
        addr_query_ok = 1'b0; // see [RQ17] [RQ22]
      end else if (addr_query_write && !sys_reg.sus_erase) begin
        addr_query_ok = 1'b0;
      end
    end
  end

  assign otp_select = sys_reg.otp_mode; // see [RQ5]
  assign lockdown_nv_write = sys_reg.lock_wr;
  assign write_latch_clear = sys_reg.wl_clr;
  assign write_latch_set = sys_reg.wl_set;
  assign write_busy_set = sys_reg.busy_set;
  assign suspend_hold = (sys_reg.sus != SUS_IDLE);
  assign security_reg = sys_reg.sec;

endmodule : otp_suspend_ctrl

// [src/otp_suspend_pkg.sv]
package otp_suspend_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_SFDP_READ = 8'h5A;
  localparam logic [7:0] OP_ID_READ = 8'h9F;
  localparam logic [7:0] OP_MAKER_ID_READ = 8'h90;
  localparam logic [7:0] OP_OTP_ENTER = 8'hB1;
  localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
  localparam logic [7:0] OP_BURST_LEN_SET = 8'hC0;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_RESUME_A = 8'h7A;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h38;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_CONFIG_READ = 8'h15;
  localparam logic [7:0] OP_SEC_READ = 8'h2B;
  localparam logic [7:0] OP_SIGNATURE_READ = 8'hAB;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_GO = 8'h99;
  localparam logic [7:0] OP_NOP = 8'h00;

  // ----------------------------------------
  // Security register layout
  // ----------------------------------------
  localparam int SEC_FACTORY_BIT = 0;
  localparam int SEC_LOCK_BIT = 1;
  localparam int SEC_PSUS_BIT = 2;
  localparam int SEC_ESUS_BIT = 3;
  localparam int SEC_PFAIL_BIT = 5;
  localparam int SEC_EFAIL_BIT = 6;
  localparam logic SEC_VOLATILE_RESET = 1'b0;

  // ----------------------------------------
  // Address regions
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int PAGE_LSB = 8;
  localparam int SECTOR_4K_LSB = 12;
  localparam int BLOCK_32K_LSB = 15;
  localparam int BLOCK_64K_LSB = 16;
  localparam int OTP_HALF_BIT = 9;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SUS_CNT_W = 16;

  typedef enum logic [1:0] {
    SIZE_SECTOR_4K = 2'b00,
    SIZE_BLOCK_32K = 2'b01,
    SIZE_BLOCK_64K = 2'b10
  } erase_size_t;

  typedef enum logic [2:0] {
    SUS_IDLE = 3'b001,
    SUS_WAIT = 3'b010,
    SUS_HELD = 3'b100
  } sus_state_t;

endpackage : otp_suspend_pkg
